//--- rtl/deser_power_link_startup.sv
/*
 * Power-state and link-startup controller of a serial-link deserializer,
 * with spread-spectrum setup, sleep, power-down and strap relatching,
 * reached by software over an AXI4-Lite slave.
 * Assumes the core clock comes from the internal oscillator, so it runs
 * with or without a recovered link clock; all inputs are synchronous.
 */
`timescale 1ns/100ps
`include "deser_cfg.svh"
module deser_power_link_startup
	import deser_pkg::*;
#(
	parameter int unsigned SLEEP_TIMEOUT_CYC = `SLEEP_TIMEOUT_NS / `CORE_CLK_PERIOD_NS
) (
	// clock, reset, enable
	input  wire logic                CORE_CLK_IN,
	input  wire logic                RST_IN,
	input  wire logic                CLK_EN_IN,
	// pins and straps
	input  wire logic                POWER_DOWN_N_IN,
	input  wire logic                SPREAD_STRAP_IN,
	input  wire logic                EQUALIZER_STRAP_IN,
	input  wire logic                DATA_RATE_STRAP_IN,
	input  wire logic [1:0]          ADDR_STRAP_IN,
	input  wire logic                MODE_SELECT_PIN_IN,
	input  wire logic                CONTROL_SIDE_SELECT_IN,
	// link status from the receiver
	input  wire logic                LINK_ACTIVITY_IN,
	input  wire logic                LOCK_IN,
	input  wire logic                WAKEUP_IN,
	input  wire logic                CONFIG_LINK_IN,
	// control outputs
	output logic                     OUTPUT_ENABLE_OUT,
	output logic                     LOCK_ENABLE_OUT,
	output logic                     SLEEP_OUT,
	output logic                     CTRL_CHANNEL_READY_OUT,
	output logic                     CONFIG_LINK_ACTIVE_OUT,
	output logic [1:0]               SPREAD_SEL_OUT,
	output logic [4:0]               SAWTOOTH_DIVIDER_OUT,
	output logic                     EQUALIZER_STRAP_OUT,
	output logic                     DATA_RATE_STRAP_OUT,
	output logic [1:0]               ADDR_STRAP_OUT,
	// AXI4-Lite slave
	input  wire logic [`ADDR_W-1:0]  S_AXI_AWADDR,
	input  wire logic                S_AXI_AWVALID,
	output logic                     S_AXI_AWREADY,
	input  wire logic [31:0]         S_AXI_WDATA,
	input  wire logic [3:0]          S_AXI_WSTRB,
	input  wire logic                S_AXI_WVALID,
	output logic                     S_AXI_WREADY,
	output logic [1:0]               S_AXI_BRESP,
	output logic                     S_AXI_BVALID,
	input  wire logic                S_AXI_BREADY,
	input  wire logic [`ADDR_W-1:0]  S_AXI_ARADDR,
	input  wire logic                S_AXI_ARVALID,
	output logic                     S_AXI_ARREADY,
	output logic [31:0]              S_AXI_RDATA,
	output logic [1:0]               S_AXI_RRESP,
	output logic                     S_AXI_RVALID,
	input  wire logic                S_AXI_RREADY
);

	localparam int TW = `TMR_W;

	pwr_state_t       state_q;
	pwr_state_t       state_d;
	logic [1:0]       spread_q;
	logic             spread_strap_q;
	logic             sleep_q;
	logic             aw_have_q;
	logic             w_have_q;
	logic [`ADDR_W-1:0] awaddr_q;
	logic [31:0]      wdata_q;
	logic [3:0]       wstrb_q;
	logic             tmr_expired;

	// power-down acts as a register reset
	wire pd_rst = RST_IN || !POWER_DOWN_N_IN;

	// bus decode
	wire aw_hs    = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_hs     = S_AXI_WVALID && S_AXI_WREADY;
	wire ar_hs    = S_AXI_ARVALID && S_AXI_ARREADY;
	wire do_write = aw_have_q && w_have_q && !S_AXI_BVALID;
	wire wr_spr   = do_write && (awaddr_q == `REG_SPREAD);
	wire wr_slp   = do_write && (awaddr_q == `REG_SLEEP) && wstrb_q[0];
	wire wr_known = (awaddr_q == `REG_SPREAD) || (awaddr_q == `REG_SLEEP)
		|| (awaddr_q == `REG_STATUS) || (awaddr_q == `REG_STRAPS);

	// divider saturates at the limit of the spread in force
	wire [1:0] new_sel = (wr_spr && wstrb_q[0])
		? wdata_q[`SPR_SEL_MSB:`SPR_SEL_LSB] : spread_q;
	wire [4:0] raw_div = (wr_spr && wstrb_q[1])
		? wdata_q[`SPR_DIV_MSB:`SPR_DIV_LSB] : SAWTOOTH_DIVIDER_OUT;
	wire [4:0] div_lim = (new_sel == `SS_4PCT) ? `DIV_LIMIT_4PCT
		: (new_sel == `SS_2PCT) ? `DIV_LIMIT_2PCT : `DIV_LIMIT_NONE;
	wire [4:0] new_div = (raw_div > div_lim) ? div_lim : raw_div;

	// the controller side of the link can never sleep; display use ties it low
	wire sleep_capable = !CONTROL_SIDE_SELECT_IN;

	// video lock overrides the oscillator-clocked configuration link
	wire cfg_active = CONFIG_LINK_IN && !LOCK_IN;
	wire ctrl_ready = LOCK_IN || cfg_active;

	// state sequencing
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_PDOWN:      state_d = ST_STRAP;
			ST_STRAP:      state_d = (MODE_SELECT_PIN_IN && sleep_capable)
				? ST_SLEEP : ST_NORMAL;
			ST_NORMAL:     if (sleep_q) state_d = ST_SLEEP_PEND;
			ST_SLEEP_PEND: begin
				if (!sleep_q)
					state_d = ST_NORMAL;
				else if (!LINK_ACTIVITY_IN || tmr_expired)
					state_d = ST_SLEEP;
			end
			ST_SLEEP:      if (WAKEUP_IN) state_d = ST_WAKING;
			ST_WAKING: begin
				if (LOCK_IN)
					state_d = ST_NORMAL;
				else if (tmr_expired)
					state_d = ST_SLEEP;
			end
			default:       state_d = ST_PDOWN;
		endcase
	end

	wire tmr_start = (state_d == ST_SLEEP_PEND || state_d == ST_WAKING)
		&& (state_d != state_q);
	wire lock_en_d = (state_d == ST_NORMAL) || (state_d == ST_SLEEP_PEND)
		|| (state_d == ST_WAKING);

	// 8 ms window runs on the oscillator clock, valid without link clock
	timeout_counter #(.WIDTH(TW)) u_timer (
		.clk_in      (CORE_CLK_IN),
		.rst_in      (pd_rst),
		.ce_in       (CLK_EN_IN),
		.start_in    (tmr_start),
		.load_in     (TW'(SLEEP_TIMEOUT_CYC)),
		.expired_out (tmr_expired)
	);

	always_ff @(posedge CORE_CLK_IN) begin
		if (pd_rst) begin
			state_q <= ST_PDOWN;
			spread_q <= `SS_NONE;
			SAWTOOTH_DIVIDER_OUT <= `DIV_RESET;
			sleep_q <= 1'b0;
		end else if (CLK_EN_IN) begin
			state_q <= state_d;
			if (state_q == ST_STRAP) begin
				spread_q <= SPREAD_STRAP_IN ? `SS_2PCT : `SS_NONE;
				sleep_q  <= MODE_SELECT_PIN_IN && sleep_capable;
			end else begin
				spread_q <= new_sel;
				SAWTOOTH_DIVIDER_OUT <= new_div;
				if (state_q == ST_WAKING && LOCK_IN)
					sleep_q <= 1'b0;
				else if (wr_slp)
					sleep_q <= wdata_q[`SLP_BIT] && sleep_capable;
			end
		end
	end

	// straps are caught each time power-down is left
	always_ff @(posedge CORE_CLK_IN) begin
		if (CLK_EN_IN && state_q == ST_STRAP && !pd_rst) begin
			spread_strap_q      <= SPREAD_STRAP_IN;
			EQUALIZER_STRAP_OUT <= EQUALIZER_STRAP_IN;
			DATA_RATE_STRAP_OUT <= DATA_RATE_STRAP_IN;
			ADDR_STRAP_OUT      <= ADDR_STRAP_IN;
		end else if (RST_IN) begin
			spread_strap_q      <= 1'b0;
			EQUALIZER_STRAP_OUT <= 1'b0;
			DATA_RATE_STRAP_OUT <= 1'b0;
			ADDR_STRAP_OUT      <= 2'h0;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (pd_rst) begin
			OUTPUT_ENABLE_OUT      <= 1'b0;
			LOCK_ENABLE_OUT        <= 1'b0;
			SLEEP_OUT              <= 1'b0;
			CTRL_CHANNEL_READY_OUT <= 1'b0;
			CONFIG_LINK_ACTIVE_OUT <= 1'b0;
			SPREAD_SEL_OUT         <= `SS_NONE;
		end else if (CLK_EN_IN) begin
			OUTPUT_ENABLE_OUT      <= 1'b1;
			LOCK_ENABLE_OUT        <= lock_en_d;
			SLEEP_OUT              <= (state_d == ST_SLEEP);
			CTRL_CHANNEL_READY_OUT <= ctrl_ready && lock_en_d;
			CONFIG_LINK_ACTIVE_OUT <= cfg_active && lock_en_d;
			SPREAD_SEL_OUT         <= spread_q;
		end
	end

	// read side
	wire [31:0] rd_spread = {19'h0, SAWTOOTH_DIVIDER_OUT, 6'h0, spread_q};
	wire [31:0] rd_sleep  = {31'h0, sleep_q};
	wire [31:0] rd_status = {16'h0, `MOD_COEFF, 1'b0, state_q,
		CONFIG_LINK_ACTIVE_OUT, CTRL_CHANNEL_READY_OUT, SLEEP_OUT, LOCK_ENABLE_OUT};
	wire [31:0] rd_straps = {27'h0, ADDR_STRAP_OUT, DATA_RATE_STRAP_OUT,
		EQUALIZER_STRAP_OUT, spread_strap_q};
	wire        rd_known  = (S_AXI_ARADDR == `REG_SPREAD) || (S_AXI_ARADDR == `REG_SLEEP)
		|| (S_AXI_ARADDR == `REG_STATUS) || (S_AXI_ARADDR == `REG_STRAPS);
	wire [31:0] rd_mux    = (S_AXI_ARADDR == `REG_SPREAD) ? rd_spread
		: (S_AXI_ARADDR == `REG_SLEEP) ? rd_sleep
		: (S_AXI_ARADDR == `REG_STATUS) ? rd_status
		: (S_AXI_ARADDR == `REG_STRAPS) ? rd_straps : 32'h0;

	// bus handshakes stay alive through power-down so software never hangs
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
			S_AXI_ARREADY <= 1'b1;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_BRESP   <= `RESP_OKAY;
			S_AXI_RRESP   <= `RESP_OKAY;
			S_AXI_RDATA   <= 32'h0;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= 32'h0;
			wstrb_q       <= 4'h0;
		end else if (CLK_EN_IN) begin
			if (aw_hs) begin
				aw_have_q     <= 1'b1;
				awaddr_q      <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (w_hs) begin
				w_have_q     <= 1'b1;
				wdata_q      <= S_AXI_WDATA;
				wstrb_q      <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end
			if (do_write) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID  <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
			end
			if (ar_hs) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID  <= 1'b1;
				S_AXI_RDATA   <= rd_mux;
				S_AXI_RRESP   <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID  <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	AST_PDN_RESET: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		(!POWER_DOWN_N_IN) |=> (state_q == ST_PDOWN && !sleep_q && spread_q == `SS_NONE))
		else $error("power-down did not reset the registers");
	AST_OE_PDOWN: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		(!POWER_DOWN_N_IN) |=> !OUTPUT_ENABLE_OUT)
		else $error("outputs enabled during power-down");
	AST_MCU_NO_SLEEP: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		$rose(sleep_q) |-> !$past(CONTROL_SIDE_SELECT_IN))
		else $error("controller-side device took the sleep bit");
	AST_DIV_LIMIT: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		(spread_q == `SS_4PCT && SAWTOOTH_DIVIDER_OUT <= `DIV_LIMIT_4PCT)
		|| (spread_q == `SS_2PCT && SAWTOOTH_DIVIDER_OUT <= `DIV_LIMIT_2PCT)
		|| (spread_q == `SS_NONE) || (spread_q == `SS_NONE_ALT))
		else $error("sawtooth divider above its limit");
	AST_SLEEP_ENTRY: assert property (@(posedge CORE_CLK_IN) disable iff (pd_rst)
		($past(state_q) == ST_SLEEP_PEND && state_q == ST_SLEEP)
		|-> ($past(!LINK_ACTIVITY_IN) || $past(tmr_expired)))
		else $error("sleep entered without inactivity or timeout");
	AST_WAKE_LOCK: assert property (@(posedge CORE_CLK_IN) disable iff (pd_rst)
		($past(state_q) == ST_WAKING && state_q == ST_NORMAL)
		|-> (!sleep_q && $past(LOCK_IN)))
		else $error("wake completed without lock or sleep bit set");
	AST_WAKE_TIMEOUT: assert property (@(posedge CORE_CLK_IN) disable iff (pd_rst)
		($past(state_q) == ST_WAKING && state_q == ST_SLEEP)
		|-> (sleep_q && $past(tmr_expired) && !$past(LOCK_IN)))
		else $error("return to sleep without timeout or bit cleared");
	AST_IGNORE_WAKE: assert property (@(posedge CORE_CLK_IN) disable iff (pd_rst)
		(state_q == ST_NORMAL && WAKEUP_IN && !sleep_q) |=> (state_q == ST_NORMAL))
		else $error("wake-up signal acted on in normal mode");
	AST_CTRL_READY: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
		CTRL_CHANNEL_READY_OUT |-> $past(LOCK_IN || CONFIG_LINK_IN))
		else $error("control channel ready without a link");
	AST_STRAP_LATCH: assert property (@(posedge CORE_CLK_IN) disable iff (pd_rst)
		(state_q == ST_STRAP && CLK_EN_IN)
		|=> (spread_q == ($past(SPREAD_STRAP_IN) ? `SS_2PCT : `SS_NONE)
		&& sleep_q == $past(MODE_SELECT_PIN_IN && !CONTROL_SIDE_SELECT_IN)))
		else $error("strap or mode select not latched at start");

endmodule

//--- rtl/deser_cfg.svh
/*
 * Constants for the deserializer power and link-startup controller:
 * register offsets, field positions, reset values and timing figures.
 * Assumes inclusion by the power-state controller module only.
 */
`ifndef DESER_CFG_SVH
`define DESER_CFG_SVH

// register byte offsets on the AXI4-Lite slave
`define REG_SPREAD        8'h00
`define REG_SLEEP         8'h04
`define REG_STATUS        8'h08
`define REG_STRAPS        8'h0c
`define ADDR_W            8

// spread and sleep register fields
`define SPR_SEL_LSB       0
`define SPR_SEL_MSB       1
`define SPR_DIV_LSB       8
`define SPR_DIV_MSB       12
`define SLP_BIT           0

// spread select encodings
`define SS_NONE           2'h0
`define SS_2PCT           2'h1
`define SS_NONE_ALT       2'h2
`define SS_4PCT           2'h3

// sawtooth divider limits and modulation coefficient
`define DIV_LIMIT_4PCT    5'h0f
`define DIV_LIMIT_2PCT    5'h1e
`define DIV_LIMIT_NONE    5'h1f
`define DIV_RESET         5'h00
`define MOD_COEFF         8'hd0

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// timing: 8 ms sleep/lock window on a 5 ns clock
`define SLEEP_TIMEOUT_NS  8000000
`define CORE_CLK_PERIOD_NS 5
`define TMR_W             21

`endif

//--- rtl/deser_pkg.sv
/*
 * Types for the deserializer power and link-startup controller.
 * Assumes nothing beyond the compile order given by the file list.
 */
package deser_pkg;

	// gray codes along power-up -> normal -> sleep -> wake -> normal
	typedef enum logic [2:0] {
		ST_PDOWN      = 3'h0,
		ST_STRAP      = 3'h1,
		ST_NORMAL     = 3'h3,
		ST_SLEEP_PEND = 3'h2,
		ST_SLEEP      = 3'h6,
		ST_WAKING     = 3'h7
	} pwr_state_t;

endpackage

//--- rtl/timeout_counter.sv
/*
 * One-shot down counter: a start pulse loads the count, and a one-cycle
 * expiry pulse follows after that many enabled clock cycles.
 * Assumes its clock is the free-running internal oscillator domain.
 */
`timescale 1ns/100ps
module timeout_counter #(
	parameter int unsigned WIDTH = 21
) (
	// clock and control
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             ce_in,
	// timer
	input  wire logic             start_in,
	input  wire logic [WIDTH-1:0] load_in,
	output logic                  expired_out
);

	logic [WIDTH-1:0] cnt_q;
	logic             run_q;
	wire              last_tick = run_q && (cnt_q == WIDTH'(1));

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_q       <= '0;
			run_q       <= 1'b0;
			expired_out <= 1'b0;
		end else if (ce_in) begin
			expired_out <= last_tick && !start_in;
			if (start_in) begin
				cnt_q <= load_in;
				run_q <= 1'b1;
			end else if (run_q) begin
				cnt_q <= cnt_q - WIDTH'(1);
				run_q <= !last_tick;
			end
		end
	end

endmodule

//--- test/ser_partner.sv
/*
 * partner model of the paired serializer: link activity, lock, wake-up burst
 * and configuration link. assumes the bench plays the host and changes the
 * enables right after a clock edge.
 */
`timescale 1ns/100ps
module ser_partner (
	// clock and host controls
	input  wire logic       clk_in,
	input  wire logic       ser_en_in,
	input  wire logic       clink_en_in,
	input  wire logic       lock_ok_in,
	input  wire logic [3:0] lock_dly_in,
	input  wire logic       lock_en_in,
	// link status toward the deserializer
	output logic            activity_out,
	output logic            lock_out,
	output logic            wakeup_out,
	output logic            config_out
);
	logic [3:0] up_q = 4'h0;
	logic [3:0] lk_q = 4'h0;
	wire        link_on = ser_en_in | clink_en_in;
	wire        lk_try  = ser_en_in & lock_ok_in & lock_en_in;

	always_ff @(posedge clk_in) begin
		up_q <= !link_on ? 4'h0 : (up_q == 4'hf ? up_q : up_q + 4'h1);
		lk_q <= !lk_try ? 4'h0 : (lk_q == 4'hf ? lk_q : lk_q + 4'h1);
	end
	// one short burst per start, once the serializer clock has settled
	assign wakeup_out   = up_q >= 4'h3 && up_q <= 4'h6;
	assign activity_out = link_on;
	// lock delay is the bench's choice, so lock can be prompt or slow
	assign lock_out     = lk_q > lock_dly_in;
	// config link stays up; the receiver itself must let video lock override it
	assign config_out   = clink_en_in & lock_en_in;
endmodule

//--- test/testbench.sv
/*
 * self-checking bench for the power and link-startup controller.
 * assumes the serializer partner model and a short sleep timeout.
 */
`timescale 1ns/100ps
module testbench;
	import deser_pkg::*;
	localparam int T = 20;
	logic        clk = 1'b0, rst = 1'b1, pdn = 1'b1, mode_sel = 1'b0;
	logic        ctl_side = 1'b0;
	logic        ss = 1'b0, eq = 1'b0, dr = 1'b0, ser_en = 1'b0, clink = 1'b0;
	logic        lock_ok = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [1:0]  ad = 2'h0;
	logic [3:0]  dly = 4'h2;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        act, lock, wake, cfg, oe, lke, slp, rdy, cfa, eqo, dro;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  sso, ado, bresp, rresp;
	logic [4:0]  divo;
	logic [31:0] rdata;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rd_t;
	rd_t         q[$];
	rd_t         me;
	int          n_fail = 0, checked = 0;
	wire [3:0]   obs = {cfa, rdy, slp, oe};

	deser_power_link_startup #(.SLEEP_TIMEOUT_CYC(T)) u_deser_power_link_startup (
		.CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(1'b1), .POWER_DOWN_N_IN(pdn),
		.SPREAD_STRAP_IN(ss), .EQUALIZER_STRAP_IN(eq), .DATA_RATE_STRAP_IN(dr),
		.ADDR_STRAP_IN(ad), .MODE_SELECT_PIN_IN(mode_sel), .CONTROL_SIDE_SELECT_IN(ctl_side),
		.LINK_ACTIVITY_IN(act), .LOCK_IN(lock), .WAKEUP_IN(wake), .CONFIG_LINK_IN(cfg),
		.OUTPUT_ENABLE_OUT(oe), .LOCK_ENABLE_OUT(lke), .SLEEP_OUT(slp),
		.CTRL_CHANNEL_READY_OUT(rdy), .CONFIG_LINK_ACTIVE_OUT(cfa), .SPREAD_SEL_OUT(sso),
		.SAWTOOTH_DIVIDER_OUT(divo), .EQUALIZER_STRAP_OUT(eqo), .DATA_RATE_STRAP_OUT(dro),
		.ADDR_STRAP_OUT(ado), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h3),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	ser_partner u_ser_partner (.clk_in(clk), .ser_en_in(ser_en), .clink_en_in(clink),
		.lock_ok_in(lock_ok), .lock_dly_in(dly), .lock_en_in(lke), .activity_out(act),
		.lock_out(lock), .wakeup_out(wake), .config_out(cfg));

	initial forever #2.5 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			aw = aw | awready;
			w = w | wready;
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er), "bresp");
	endtask
	// the expectation is queued here and judged by the response monitor
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] r);
		q.push_back('{d, m, r});
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready) begin
			me = q.pop_front();
			chk(rdata & me.m, me.d, "rdata");
			chk(32'(rresp), 32'(me.r), "rresp");
		end
	end
	task automatic wt(input int s, input logic v, input int mx);
		int n;
		n = 0;
		while (obs[s] !== v && n < mx) begin
			@(posedge clk);
			n++;
		end
		chk(32'(obs[s]), 32'(v), "wait");
	endtask
	task automatic startup(input logic m);
		rd(8'h0c, {27'h0, ad, dr, eq, ss}, 32'h1f, 2'h0);
		rd(8'h00, {31'h0, ss}, 32'h1f03, 2'h0);
		rd(8'h04, {31'h0, m}, 32'h1, 2'h0);
		chk(32'(slp), 32'(m), "sleep at start");
		chk(32'(oe), 32'h1, "outputs on");
		chk(32'({ado, dro, eqo}), 32'({ad, dr, eq}), "strap outputs");
		chk(32'(lke), 32'(!m), "lock enable at start");
	endtask
	task automatic pwr(input logic m);
		@(posedge clk);
		pdn <= 1'b0;
		mode_sel <= m;
		{ad, dr, eq, ss} <= 5'($urandom_range(31));
		repeat (3) @(posedge clk);
		chk(32'(oe), 32'h0, "outputs in power-down");
		pdn <= 1'b1;
		repeat (4) @(posedge clk);
		startup(m);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		print_verdict();
	end

	initial begin
		logic [1:0] sel;
		logic [4:0] d, lim;
		void'($urandom(32'h64bb9bb5));
		{ad, dr, eq, ss} <= 5'($urandom_range(31));
		dly <= 4'($urandom_range(12));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		startup(1'b0);
		rd(8'h08, {16'h0, 8'hd0, 1'b0, ST_NORMAL, 4'h0}, 32'hff70, 2'h0);
		clink <= 1'b1;
		wt(3, 1'b1, 40);
		chk(32'(rdy), 32'h1, "ready on config link");
		rd(8'h08, {25'h0, ST_NORMAL, 4'h0}, 32'h70, 2'h0);
		ser_en <= 1'b1;
		wt(3, 1'b0, 40);
		wt(2, 1'b1, 40);
		chk(32'(cfa), 32'h0, "video overrides config");
		clink <= 1'b0;
		for (int j = 0; j < 8; j++) begin
			sel = 2'(j);
			lim = (sel == 2'h3) ? 5'h0f : (sel == 2'h1) ? 5'h1e : 5'h1f;
			// first rows act as a careful host, the rest lean on the saturation
			d = (j < 4) ? 5'($urandom_range(31)) : 5'h1f;
			if (j < 4 && d > lim) d = lim;
			wr(8'h00, {19'h0, d, 6'h0, sel}, 2'h0);
			rd(8'h00, {19'h0, (d > lim) ? lim : d, 6'h0, sel}, 32'h1f03, 2'h0);
			chk(32'(sso), 32'(sel), "spread select");
			chk(32'(divo), 32'((d > lim) ? lim : d), "divider out");
		end
		rd(8'h10, 32'h0, 32'hffffffff, 2'h2);
		wr(8'h14, 32'h1, 2'h2);
		// activity stays up, so only the timer can put it to sleep
		wr(8'h04, 32'h1, 2'h0);
		repeat (T / 2) @(posedge clk);
		chk(32'(slp), 32'h0, "early sleep");
		wt(1, 1'b1, T + 8);
		ser_en <= 1'b0;
		@(posedge clk);
		ser_en <= 1'b1;
		wt(2, 1'b1, 60);
		rd(8'h04, 32'h0, 32'h1, 2'h0);
		ser_en <= 1'b0;
		wr(8'h04, 32'h1, 2'h0);
		wt(1, 1'b1, 6);
		lock_ok <= 1'b0;
		ser_en <= 1'b1;
		wt(1, 1'b0, 20);
		repeat (T - 4) @(posedge clk);
		chk(32'(slp), 32'h0, "still waking");
		wt(1, 1'b1, 12);
		rd(8'h04, 32'h1, 32'h1, 2'h0);
		ctl_side <= 1'b1;
		lock_ok <= 1'b1;
		wr(8'h00, 32'h00000a03, 2'h0);
		pwr(1'b0);
		wr(8'h04, 32'h1, 2'h0);
		rd(8'h04, 32'h0, 32'h1, 2'h0);
		ctl_side <= 1'b0;
		ser_en <= 1'b0;
		pwr(1'b1);
		ser_en <= 1'b1;
		wt(2, 1'b1, 60);
		chk(32'(slp), 32'h0, "awake after lock");
		print_verdict();
	end
endmodule
